// ### core/capcom_pkg.sv
// Shared constants and types of the dual time base capture/compare unit.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
package capcom_pkg;
    localparam int CH_N = 16;
    localparam int PIN_N = 12;
    localparam int PAIR_N = 8;
    // Register byte offsets
    localparam logic [7:0] OFF_TCTL = 8'h00;
    localparam logic [7:0] OFF_CNT1 = 8'h04;
    localparam logic [7:0] OFF_REL1 = 8'h08;
    localparam logic [7:0] OFF_CNT2 = 8'h0c;
    localparam logic [7:0] OFF_REL2 = 8'h10;
    localparam logic [7:0] OFF_FLAG = 8'h14;
    localparam logic [1:0] PAGE_VAL = 2'h1;
    localparam logic [1:0] PAGE_MODE = 2'h2;
    // Timer control fields
    localparam int TC_PRE1 = 0;
    localparam int TC_SRC1 = 3;
    localparam int TC_RUN1 = 5;
    localparam int TC_PRE2 = 8;
    localparam int TC_SRC2 = 11;
    localparam int TC_RUN2 = 13;
    localparam int TC_STAG = 15;
    // Channel mode fields
    localparam int CM_MODE = 0;
    localparam int CM_TSEL = 3;
    localparam int CM_SINGLE = 4;
    localparam int CM_DBL = 5;
    // Reset values and counts
    localparam logic [15:0] TCTL_RST = 16'h0000;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] REL_RST = 16'h0000;
    localparam logic [15:0] VAL_RST = 16'h0000;
    localparam logic [5:0] CMODE_RST = 6'h00;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [2:0] STAG_LAST = 3'h7;
    typedef enum logic [2:0] {
        MODE_OFF, CAP_RISE, CAP_FALL, CAP_BOTH, CMP_M0, CMP_M1, CMP_M2, CMP_M3
    } mode_t;
    typedef enum logic [1:0] {SRC_PRESCALE, SRC_NEIGHBOUR, SRC_EXTERNAL, SRC_NONE} src_t;
endpackage

// ### core/capcom_top.sv
// Sixteen-channel capture/compare unit on two reloadable time bases.
// Assumes a classic Wishbone master on core_clk; pins are asynchronous.
//
// The register addresses and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
// How it works
// - Sixteen capture/compare channels, one system clock resolution normally.
// - Staggered operation coarsens timing resolution to eight clock cycles.
// - Two independent 16-bit timers, each with its own reload register.
// - Timer clock chosen from prescaled divisions of system clock.
// - Timers may count overflows of the neighbouring timer instead.
// - First time base may count an external count input.
// - Each channel is allocated to first or second time base.
// - Each channel is set to capture or to compare.
// - Twelve channels own a pin: capture input or compare output.
// - Compare mode 0: match raises request only, many per period.
// - Compare mode 1: pin toggles on every match.
// - Compare mode 2: request only, at most one per period.
// - Compare mode 3: pin high on match, low on timer overflow.
// - Double register: two channels toggle one pin on either match.
// - Single event option gives one edge or pulse only.
// - Capture latches allocated timer on pin event and raises request.
// - Capture trigger is rising, falling or both edges.
// - Compare channels compare continuously; match triggers mode action.
module capcom_top (
    input wire logic core_clk, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic cyc_i, // Wishbone cycle
    input wire logic stb_i, // Wishbone strobe
    input wire logic we_i, // Wishbone write
    input wire logic [7:0] adr_i, // Byte address
    input wire logic [3:0] sel_i, // Byte enables
    input wire logic [31:0] dat_i, // Write data
    output logic [31:0] dat_o, // Read data
    output logic ack_o, // Wishbone acknowledge
    input wire logic [11:0] capIn, // Channel pins in
    output logic [11:0] cmpOut, // Channel pins out
    output logic [11:0] cmpOe, // Channel pin enables
    input wire logic extCount, // External count pin
    input wire logic neighbourOvf, // Neighbour timer overflow
    output logic [15:0] chanReq // Channel request pulses
);
    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic [15:0] tctl;
        logic [15:0] flags;
        logic [15:0] req;
        logic [7:0] pre;
        logic [2:0] stag;
        logic [11:0] pin;
        logic [11:0] oe;
        logic [11:0] s1;
        logic [11:0] s2;
        logic [11:0] s3;
        logic [11:0] lvl;
        logic [2:0] xs;
        logic xl;
        logic [15:0][5:0] cmode;
    } state_t;
    state_t s_r, s_nxt;

    logic acc, wr, stagOn, step, tick1, tick2, ovf1, ovf2, xRise;
    logic [11:0] pRise, pFall;
    logic [15:0] cnt1, rel1, cnt2, rel2, mw;
    logic [15:0] fireW, evW, tglW, setW, clrW, modeWr, valWr, partnerW;
    logic [15:0][15:0] valW;

    // Merge byte lanes into a 16-bit register
    function automatic logic [15:0] lanes(input logic [15:0] o, input logic [31:0] d,
                                          input logic [3:0] s);
        lanes = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
    endfunction

    // Tick once every 2^sel cycles
    function automatic logic preTick(input logic [7:0] pre, input logic [2:0] sel);
        logic [7:0] mask;
        mask = 8'((9'h001 << sel) - 9'h001);
        preTick = ((pre & mask) == mask);
    endfunction

    function automatic logic srcTick(input logic [1:0] src, input logic pt,
                                     input logic nb, input logic ext);
        case (capcom_pkg::src_t'(src))
            capcom_pkg::SRC_PRESCALE: srcTick = pt;
            capcom_pkg::SRC_NEIGHBOUR: srcTick = nb;
            capcom_pkg::SRC_EXTERNAL: srcTick = ext;
            default: srcTick = 1'b0;
        endcase
    endfunction

    assign acc = cyc_i && stb_i && !s_r.ack;
    assign wr = acc && we_i;
    assign stagOn = s_r.tctl[capcom_pkg::TC_STAG];
    assign step = !stagOn || (s_r.stag == capcom_pkg::STAG_LAST);

    // Debounced edges on the stable level of the synchronised pins
    assign pRise = (s_r.s2 ~^ s_r.s3) & s_r.s2 & ~s_r.lvl;
    assign pFall = (s_r.s2 ~^ s_r.s3) & ~s_r.s2 & s_r.lvl;
    assign xRise = (s_r.xs[1] == s_r.xs[2]) && s_r.xs[1] && !s_r.xl;

    assign tick1 = s_r.tctl[capcom_pkg::TC_RUN1]
        && srcTick(s_r.tctl[capcom_pkg::TC_SRC1 +: 2],
                   step && preTick(s_r.pre, s_r.tctl[capcom_pkg::TC_PRE1 +: 3]),
                   neighbourOvf, xRise);
    // Second time base has no external count input
    assign tick2 = s_r.tctl[capcom_pkg::TC_RUN2]
        && srcTick(s_r.tctl[capcom_pkg::TC_SRC2 +: 2],
                   step && preTick(s_r.pre, s_r.tctl[capcom_pkg::TC_PRE2 +: 3]),
                   neighbourOvf, 1'b0);

    cc_timer u_first_timebase (
        .core_clk(core_clk),
        .rst(rst),
        .tick(tick1),
        .wrCnt(wr && (adr_i == capcom_pkg::OFF_CNT1)),
        .wrRel(wr && (adr_i == capcom_pkg::OFF_REL1)),
        .wdat(lanes(adr_i == capcom_pkg::OFF_CNT1 ? cnt1 : rel1, dat_i, sel_i)),
        .cnt(cnt1),
        .rel(rel1),
        .ovf(ovf1)
    );

    cc_timer u_second_timebase (
        .core_clk(core_clk),
        .rst(rst),
        .tick(tick2),
        .wrCnt(wr && (adr_i == capcom_pkg::OFF_CNT2)),
        .wrRel(wr && (adr_i == capcom_pkg::OFF_REL2)),
        .wdat(lanes(adr_i == capcom_pkg::OFF_CNT2 ? cnt2 : rel2, dat_i, sel_i)),
        .cnt(cnt2),
        .rel(rel2),
        .ovf(ovf2)
    );

    generate
        for (genvar i = 0; i < capcom_pkg::CH_N; i++) begin : g_ch
            logic tsel;
            assign tsel = s_r.cmode[i][capcom_pkg::CM_TSEL];
            assign valWr[i] = wr && (adr_i[7:6] == capcom_pkg::PAGE_VAL)
                && (adr_i[5:2] == 4'(i));
            assign modeWr[i] = wr && (adr_i[7:6] == capcom_pkg::PAGE_MODE)
                && (adr_i[5:2] == 4'(i));
            if (i < capcom_pkg::PAIR_N) begin : g_pair
                assign partnerW[i] = s_r.cmode[i][capcom_pkg::CM_DBL]
                    && fireW[i + capcom_pkg::PAIR_N];
            end else begin : g_solo
                assign partnerW[i] = 1'b0;
            end
            cc_channel u_ch (
                .core_clk(core_clk),
                .rst(rst),
                .wrVal(valWr[i]),
                .wdat(lanes(valW[i], dat_i, sel_i)),
                .mode(s_r.cmode[i]),
                .modeWr(modeWr[i]),
                .tmrVal(tsel ? cnt2 : cnt1),
                .tmrOvf(tsel ? ovf2 : ovf1),
                .cmpEn(!stagOn || (s_r.stag == 3'(i))),
                .rise(i < capcom_pkg::PIN_N ? pRise[i % capcom_pkg::PIN_N] : 1'b0),
                .fall(i < capcom_pkg::PIN_N ? pFall[i % capcom_pkg::PIN_N] : 1'b0),
                .partner(partnerW[i]),
                .val(valW[i]),
                .fire(fireW[i]),
                .event_o(evW[i]),
                .tgl(tglW[i]),
                .setPin(setW[i]),
                .clrPin(clrW[i])
            );
        end
    endgenerate

    always_comb begin
        mw = 16'h0000;
        s_nxt = s_r;
        s_nxt.ack = acc;
        s_nxt.rdat = 32'h0000_0000;
        s_nxt.pre = s_r.pre + 8'h01;
        s_nxt.stag = s_r.stag + 3'h1;
        s_nxt.s1 = capIn;
        s_nxt.s2 = s_r.s1;
        s_nxt.s3 = s_r.s2;
        s_nxt.lvl = (s_r.s2 & ~(s_r.s2 ^ s_r.s3)) | (s_r.lvl & (s_r.s2 ^ s_r.s3));
        s_nxt.xs = {s_r.xs[1:0], extCount};
        if (s_r.xs[1] == s_r.xs[2]) begin
            s_nxt.xl = s_r.xs[1];
        end
        // Read data
        if (acc && !we_i) begin
            case (adr_i[7:6])
                capcom_pkg::PAGE_VAL: s_nxt.rdat = {16'h0000, valW[adr_i[5:2]]};
                capcom_pkg::PAGE_MODE: s_nxt.rdat = {26'h0, s_r.cmode[adr_i[5:2]]};
                default: begin
                    case (adr_i)
                        capcom_pkg::OFF_TCTL: s_nxt.rdat = {16'h0000, s_r.tctl};
                        capcom_pkg::OFF_CNT1: s_nxt.rdat = {16'h0000, cnt1};
                        capcom_pkg::OFF_REL1: s_nxt.rdat = {16'h0000, rel1};
                        capcom_pkg::OFF_CNT2: s_nxt.rdat = {16'h0000, cnt2};
                        capcom_pkg::OFF_REL2: s_nxt.rdat = {16'h0000, rel2};
                        capcom_pkg::OFF_FLAG: s_nxt.rdat = {16'h0000, s_r.flags};
                        default: s_nxt.rdat = 32'h0000_0000;
                    endcase
                end
            endcase
        end
        // Writes
        if (wr && (adr_i == capcom_pkg::OFF_TCTL)) begin
            s_nxt.tctl = lanes(s_r.tctl, dat_i, sel_i);
        end
        for (int i = 0; i < capcom_pkg::CH_N; i++) begin
            if (modeWr[i]) begin
                mw = lanes({10'h000, s_r.cmode[i]}, dat_i, sel_i);
                s_nxt.cmode[i] = mw[5:0];
            end
        end
        // Write one clears; a new event wins
        s_nxt.flags = s_r.flags;
        if (wr && (adr_i == capcom_pkg::OFF_FLAG)) begin
            s_nxt.flags = s_r.flags & ~lanes(16'h0000, dat_i, sel_i);
        end
        s_nxt.flags = s_nxt.flags | evW;
        s_nxt.req = evW;
        // Pin actions; setting wins over clearing
        for (int i = 0; i < capcom_pkg::PIN_N; i++) begin
            if (setW[i]) begin
                s_nxt.pin[i] = 1'b1;
            end else if (clrW[i]) begin
                s_nxt.pin[i] = 1'b0;
            end else if (tglW[i]) begin
                s_nxt.pin[i] = !s_r.pin[i];
            end
            s_nxt.oe[i] = (s_r.cmode[i][2:0] == 3'(capcom_pkg::CMP_M1))
                || (s_r.cmode[i][2:0] == 3'(capcom_pkg::CMP_M3))
                || s_r.cmode[i][capcom_pkg::CM_DBL];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_r <= '0;
            s_r.tctl <= capcom_pkg::TCTL_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign ack_o = s_r.ack;
    assign dat_o = s_r.rdat;
    assign cmpOut = s_r.pin;
    assign cmpOe = s_r.oe;
    assign chanReq = s_r.req;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence pinRiseHeld;
        $rose(capIn[0]) ##1 capIn[0] [*3];
    endsequence

    a_bus_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("acknowledge held longer than one cycle");
    a_stag_step_slot: assert property (
        (stagOn && tick1 && (s_r.tctl[capcom_pkg::TC_SRC1 +: 2] == 2'h0))
        |-> (s_r.stag == capcom_pkg::STAG_LAST))
        else $error("staggered timer advanced off its slot");
    a_flag_set_wins: assert property (
        (evW != 16'h0000) |=> ((s_r.flags & $past(evW)) == $past(evW)))
        else $error("channel event lost from flags");
    a_req_follows_event: assert property (
        ##1 (chanReq == $past(evW)))
        else $error("request pulse does not follow event");
    a_pin_toggle: assert property (
        (tglW[0] && !setW[0] && !clrW[0]) |=> (cmpOut[0] != $past(cmpOut[0])))
        else $error("pin did not toggle on match");
    a_pin_set_mode3: assert property (setW[0] |=> cmpOut[0])
        else $error("pin not set on mode 3 match");
    a_pin_clr_mode3: assert property ((clrW[0] && !setW[0]) |=> !cmpOut[0])
        else $error("pin not cleared on overflow");
    a_sync_level: assert property (pinRiseHeld |=> s_r.lvl[0])
        else $error("synchronised level missed a held rise");
    a_capture_latch: assert property (
        (pRise[7] && (s_r.cmode[7][2:0] == 3'(capcom_pkg::CAP_BOTH)) && !valWr[7]
         && s_r.cmode[7][capcom_pkg::CM_TSEL]) |=> (valW[7] == $past(cnt2)))
        else $error("capture did not latch the timer");
endmodule // capcom_top

// ### core/cc_channel.sv
// One capture/compare channel register with its mode logic.
// Assumes edges are already synchronised and timer inputs are selected.
`timescale 1ns/1ps
module cc_channel (
    input wire logic core_clk, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic wrVal, // Bus write of value
    input wire logic [15:0] wdat, // Write data
    input wire logic [5:0] mode, // Mode field
    input wire logic modeWr, // Mode field written
    input wire logic [15:0] tmrVal, // Allocated timer
    input wire logic tmrOvf, // Allocated timer overflow
    input wire logic cmpEn, // Compare slot
    input wire logic rise, // Pin rising edge
    input wire logic fall, // Pin falling edge
    input wire logic partner, // Partner match
    output logic [15:0] val, // Register value
    output logic fire, // Compare event
    output logic event_o, // Request event
    output logic tgl, // Toggle pin
    output logic setPin, // Drive pin high
    output logic clrPin // Drive pin low
);
    typedef struct packed {
        logic [15:0] val;
        logic seen;
        logic armed;
        logic done;
    } cstate_t;
    cstate_t s_r, s_nxt;
    capcom_pkg::mode_t m;
    logic isCmp, eq, hitRaw, once, capEv;

    always_comb begin
        m = capcom_pkg::mode_t'(mode[capcom_pkg::CM_MODE +: 3]);
        isCmp = (m >= capcom_pkg::CMP_M0);
        eq = (s_r.val == tmrVal);
        hitRaw = isCmp && cmpEn && eq && !s_r.seen;
        once = (m == capcom_pkg::CMP_M2) || (m == capcom_pkg::CMP_M3);
        fire = hitRaw && !s_r.done && (!once || s_r.armed);
        capEv = (((m == capcom_pkg::CAP_RISE) || (m == capcom_pkg::CAP_BOTH)) && rise)
            || (((m == capcom_pkg::CAP_FALL) || (m == capcom_pkg::CAP_BOTH)) && fall);
        event_o = fire || capEv;
        tgl = (fire && ((m == capcom_pkg::CMP_M1) || mode[capcom_pkg::CM_DBL]))
            || partner;
        setPin = fire && (m == capcom_pkg::CMP_M3);
        clrPin = tmrOvf && (m == capcom_pkg::CMP_M3);
        s_nxt = s_r;
        s_nxt.seen = eq && (s_r.seen || hitRaw);
        if (wrVal) begin
            s_nxt.val = wdat;
        end else if (capEv) begin
            s_nxt.val = tmrVal;
        end
        if (modeWr || tmrOvf) begin
            s_nxt.armed = 1'b1;
        end else if (fire && once) begin
            s_nxt.armed = 1'b0;
        end
        if (modeWr) begin
            s_nxt.done = 1'b0;
        end else if (fire && mode[capcom_pkg::CM_SINGLE]) begin
            s_nxt.done = 1'b1;
        end
    end

    assign val = s_r.val;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_r <= {capcom_pkg::VAL_RST, 1'b0, 1'b1, 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    a_single_event_once: assert property (@(posedge core_clk) disable iff (rst)
        (fire && mode[capcom_pkg::CM_SINGLE] && !modeWr) ##1 !modeWr |-> !fire)
        else $error("single event channel fired twice");
    a_once_per_period: assert property (@(posedge core_clk) disable iff (rst)
        (fire && once && !tmrOvf && !modeWr) ##1 (!tmrOvf && !modeWr) |-> !fire)
        else $error("second compare event within one period");
endmodule // cc_channel

// ### core/cc_timer.sv
// One reloadable 16-bit time base.
// Assumes tick is a single-cycle advance strobe from the same clock.
`timescale 1ns/1ps
module cc_timer (
    input wire logic core_clk, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic tick, // Advance by one
    input wire logic wrCnt, // Load count
    input wire logic wrRel, // Load reload
    input wire logic [15:0] wdat, // Write data
    output logic [15:0] cnt, // Current count
    output logic [15:0] rel, // Reload value
    output logic ovf // Overflow this cycle
);
    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] rel;
    } tstate_t;
    tstate_t s_r, s_nxt;

    assign cnt = s_r.cnt;
    assign rel = s_r.rel;
    assign ovf = tick && (s_r.cnt == capcom_pkg::CNT_MAX);

    always_comb begin
        s_nxt = s_r;
        if (wrRel) begin
            s_nxt.rel = wdat;
        end
        if (wrCnt) begin
            s_nxt.cnt = wdat;
        end else if (ovf) begin
            s_nxt.cnt = s_r.rel;
        end else if (tick) begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_r <= {capcom_pkg::CNT_RST, capcom_pkg::REL_RST};
        end else begin
            s_r <= s_nxt;
        end
    end

    a_reload_on_ovf: assert property (@(posedge core_clk) disable iff (rst)
        (ovf && !wrCnt) |=> (s_r.cnt == $past(s_r.rel)))
        else $error("timer not reloaded after overflow");
endmodule // cc_timer

// ### tb/cc_pin_model.sv
// Pin-side model: capture pins, external count pin and neighbour overflow.
// Assumes the unit samples all of these on rising edges of core_clk.
`timescale 1ns/1ps
module cc_pin_model (
    input wire logic core_clk, // System clock
    input wire logic [11:0] cmpOut, // Unit pin levels
    input wire logic [11:0] cmpOe, // Unit pin enables
    output logic [11:0] capIn, // Pin levels seen by unit
    output logic extCount, // External count pin
    output logic neighbourOvf // Neighbour overflow pulse
);
    logic [11:0] drv;
    // A pin the unit drives reads back its own level
    assign capIn = (cmpOe & cmpOut) | (~cmpOe & drv);
    initial begin
        drv = 12'h000;
        extCount = 1'b0;
        neighbourOvf = 1'b0;
    end
    // Level held past the synchroniser depth
    task automatic setPin(input int ch, input logic lvl);
        @(posedge core_clk);
        drv[ch] <= lvl;
        repeat (4) @(posedge core_clk);
    endtask
    task automatic countPulses(input int n, input logic ext);
        repeat (n) begin
            @(posedge core_clk);
            if (ext) extCount <= 1'b1;
            else neighbourOvf <= 1'b1;
            @(posedge core_clk);
            neighbourOvf <= 1'b0;
            repeat (3) @(posedge core_clk);
            extCount <= 1'b0;
            repeat (4) @(posedge core_clk);
        end
    endtask
endmodule // cc_pin_model

// ### tb/tb_top.sv
// Self-checking bench of the capture/compare unit.
// Assumes the Wishbone map and mode encodings of the design package.
`timescale 1ns/1ps
module tb_top;
    logic core_clk, rst, cyc, stb, we, ack, lvl, p1;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, rd, v;
    logic [11:0] capIn, cmpOut, cmpOe;
    logic extCount, neighbourOvf;
    logic [15:0] chanReq;
    int errors, compares, n1, n3, n4, n5;
    longint t0;
    capcom_top DUT (.core_clk(core_clk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rd), .ack_o(ack), .capIn(capIn),
        .cmpOut(cmpOut), .cmpOe(cmpOe), .extCount(extCount), .neighbourOvf(neighbourOvf),
        .chanReq(chanReq));
    cc_pin_model pm (.core_clk(core_clk), .cmpOut(cmpOut), .cmpOe(cmpOe), .capIn(capIn),
        .extCount(extCount), .neighbourOvf(neighbourOvf));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge core_clk);
            k++;
        end while (ack !== 1'b1 && k < 50);
        rdat = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (k >= 50) check({31'h0, ack}, 32'h1);
        @(posedge core_clk);
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        check(rdat, exp);
    endtask
    task automatic setMode(input int ch, input logic [5:0] m, input logic [15:0] val);
        wb(1'b1, 8'(64 + 4 * ch), {16'h0, val});
        wb(1'b1, 8'(128 + 4 * ch), {26'h0, m});
    endtask
    task automatic waitReq(input int ch);
        int k;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (chanReq[ch] !== 1'b1 && k < 1000);
        check({31'h0, chanReq[ch]}, 32'h1);
    endtask
    task automatic tally_and_finish();
        $display("Counts: %0d compares, %0d errors", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        #400000;
        errors++;
        tally_and_finish();
    end
    initial begin
        rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'hf;
        wdat = 32'h0;
        void'($urandom(84));
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        rdChk(capcom_pkg::OFF_TCTL, 32'h0);
        rdChk(8'h30, 32'h0);
        for (int i = 0; i < 8; i++) begin
            v = {16'h0, 16'($urandom)};
            wb(1'b1, capcom_pkg::OFF_REL2, v);
            rdChk(capcom_pkg::OFF_REL2, v);
        end
        $display("Test registers done");
        wb(1'b1, capcom_pkg::OFF_REL1, 32'hff00);
        wb(1'b1, capcom_pkg::OFF_CNT1, 32'hff00);
        setMode(0, 6'h05, 16'hff10);
        setMode(2, 6'h07, 16'hff80);
        wb(1'b1, capcom_pkg::OFF_TCTL, 32'h20);
        waitReq(0);
        t0 = $time;
        repeat (3) @(posedge core_clk);
        check({31'h0, cmpOe[0]}, 32'h1);
        lvl = cmpOut[0];
        waitReq(0);
        check(32'(($time - t0) / 20), 32'd256);
        repeat (3) @(posedge core_clk);
        check({31'h0, cmpOut[0]}, {31'h0, ~lvl});
        waitReq(2);
        repeat (3) @(posedge core_clk);
        check({31'h0, cmpOut[2]}, 32'h1);
        repeat (150) @(posedge core_clk);
        check({31'h0, cmpOut[2]}, 32'h0);
        $display("Test compare pins done");
        setMode(4, 6'h04, 16'hffc0);
        setMode(5, 6'h06, 16'hffc0);
        setMode(3, 6'h14, 16'hffc0);
        setMode(1, 6'h24, 16'hff40);
        setMode(9, 6'h04, 16'hff60);
        n1 = 0;
        p1 = cmpOut[1];
        n3 = 0;
        n4 = 0;
        n5 = 0;
        repeat (512) begin
            @(posedge core_clk);
            n3 += int'(chanReq[3]);
            n4 += int'(chanReq[4]);
            n5 += int'(chanReq[5]);
            n1 += int'(cmpOut[1] != p1);
            p1 = cmpOut[1];
        end
        check(n1, 4);
        check(n3, 1);
        check(n4, 2);
        check(n5, 2);
        $display("Test request modes done");
        wb(1'b1, capcom_pkg::OFF_TCTL, 32'h0);
        wb(1'b1, capcom_pkg::OFF_CNT2, 32'h5678);
        setMode(7, 6'h0b, 16'h0);
        setMode(8, 6'h0a, 16'h0);
        pm.setPin(8, 1'b1);
        pm.setPin(7, 1'b1);
        repeat (4) @(posedge core_clk);
        rdChk(8'h60, 32'h0);
        rdChk(8'h5c, 32'h5678);
        wb(1'b1, capcom_pkg::OFF_CNT2, 32'h1357);
        pm.setPin(7, 1'b0);
        pm.setPin(8, 1'b0);
        repeat (4) @(posedge core_clk);
        rdChk(8'h5c, 32'h1357);
        rdChk(8'h60, 32'h1357);
        $display("Test capture done");
        wb(1'b1, capcom_pkg::OFF_CNT1, 32'h0);
        wb(1'b1, capcom_pkg::OFF_TCTL, 32'h28);
        pm.countPulses(5, 1'b0);
        rdChk(capcom_pkg::OFF_CNT1, 32'h5);
        wb(1'b1, capcom_pkg::OFF_CNT1, 32'h0);
        wb(1'b1, capcom_pkg::OFF_TCTL, 32'h30);
        pm.countPulses(3, 1'b1);
        rdChk(capcom_pkg::OFF_CNT1, 32'h3);
        for (int i = 0; i < 2; i++) begin
            wb(1'b1, capcom_pkg::OFF_TCTL, 32'h0);
            wb(1'b1, capcom_pkg::OFF_CNT1, 32'h0);
            wb(1'b1, capcom_pkg::OFF_TCTL, (i == 0) ? 32'h23 : 32'h8020);
            repeat (80) @(posedge core_clk);
            wb(1'b1, capcom_pkg::OFF_TCTL, 32'h0);
            wb(1'b0, capcom_pkg::OFF_CNT1, 32'h0);
            check({31'h0, rdat >= 32'd9 && rdat <= 32'd11}, 32'h1);
        end
        $display("Test clock sources done");
        tally_and_finish();
    end
endmodule // tb_top
